// *** include/vtlm_pkg.sv ***
`default_nettype none
package vtlm_pkg;

    // Command codes of the three words held here
    localparam logic [7:0]  CMD_TRIM        = 8'h22;
    localparam logic [7:0]  CMD_MAX         = 8'h24;
    localparam logic [7:0]  CMD_MARGIN_HIGH = 8'h25;

    // Values after reset (non-volatile restore is outside this block)
    localparam logic [15:0] TRIM_RST        = 16'h0000;
    localparam logic [15:0] MAX_RST         = 16'hffff;
    localparam logic [15:0] MARGIN_HIGH_RST = 16'h0000;

    // Exponent handling: internal units are 2^-12 V
    localparam int          EXP_MIN         = -12;
    localparam int          EXP_MAX         = -4;
    localparam int          NVM_BYTE_MAX    = 127;
    localparam int          NVM_BYTE_MIN    = -128;

    // DAC ceiling per loop scale, in mV, and the same in internal units
    localparam int          LSB_PER_VOLT    = 4096;
    localparam int          MV_PER_VOLT     = 1000;
    localparam int          DAC_MV_S1       = 700;
    localparam int          DAC_MV_S05      = 1400;
    localparam int          DAC_MV_S025     = 2800;
    localparam int          DAC_MV_S0125    = 6000;
    localparam int          DAC_MAX_S1      = DAC_MV_S1 * LSB_PER_VOLT / MV_PER_VOLT;
    localparam int          DAC_MAX_S05     = DAC_MV_S05 * LSB_PER_VOLT / MV_PER_VOLT;
    localparam int          DAC_MAX_S025    = DAC_MV_S025 * LSB_PER_VOLT / MV_PER_VOLT;
    localparam int          DAC_MAX_S0125   = DAC_MV_S0125 * LSB_PER_VOLT / MV_PER_VOLT;

    // Bit positions within a link byte
    localparam logic [3:0]  BIT_LAST        = 4'h7;
    localparam logic [3:0]  BIT_ACK         = 4'h8;
    localparam logic [7:0]  IDLE_BYTE       = 8'hff;

    typedef enum logic [1:0] {VTLM_SCALE_1, VTLM_SCALE_05, VTLM_SCALE_025, VTLM_SCALE_0125} vtlm_scale_t;

    typedef enum logic [2:0] {LS_IDLE, LS_SKIP, LS_ADDR, LS_CMD, LS_DLO, LS_DHI, LS_RLO, LS_RHI} vtlm_link_state_t;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] data;
    } vtlm_word_t;

    typedef struct packed {
        logic none_above;
        logic word_vout;
        logic vout_maxmin;
        logic cml_invalid;
    } vtlm_status_t;

endpackage
`default_nettype wire

// *** logic/vtlm_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module vtlm_core #(
    parameter logic [6:0] DEV_ADDR = 7'h40
) (
    // System
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Management link
    input  wire logic                  pmb_scl,
    input  wire logic                  pmb_sda_i,
    output logic                       pmb_sda_o,
    output logic                       pmb_sda_oe,
    output logic                       pmb_alert_o,
    output logic                       pmb_alert_oe,
    // Converter settings
    input  wire logic [15:0]           vout_command,
    input  wire logic [15:0]           vout_min,
    input  wire logic [4:0]            vout_exp,
    input  wire logic                  vout_rel,
    input  wire logic                  margin_high_sel,
    input  wire logic                  conv_en,
    input  wire vtlm_pkg::vtlm_scale_t loop_scale,
    input  wire logic [15:0]           ramp_interval,
    input  wire logic                  status_clear,
    // Results
    output logic [15:0]                dac_ref,
    output logic [7:0]                 nvm_trim_byte,
    output vtlm_pkg::vtlm_status_t     status
);

    // Link domain
    vtlm_pkg::vtlm_link_state_t lstate;
    logic                       lrst_s1;
    logic                       lrst_s2;
    logic                       rdack_s1;
    logic                       rdack_s2;
    logic                       sda_pos;
    logic [3:0]                 bit_cnt;
    logic [7:0]                 rx_shift;
    logic [7:0]                 tx_shift;
    logic [7:0]                 tx_hi;
    logic                       rw_read;
    logic [7:0]                 lcmd;
    logic [7:0]                 data_lo;
    vtlm_pkg::vtlm_word_t       wr_hold;
    logic                       wr_tog;
    logic                       rd_tog;
    logic [7:0]                 rx_byte;
    logic                       ack_now;
    logic                       start_seen;
    logic                       rd_ready;
    logic [15:0]                tx_word;

    // System domain
    logic                       wr_s1;
    logic                       wr_s2;
    logic                       wr_s3;
    logic                       rd_s1;
    logic                       rd_s2;
    logic                       rd_s3;
    logic                       rd_ack;
    logic [15:0]                rd_data;
    logic [15:0]                trim;
    logic [15:0]                vmax;
    logic [15:0]                margin;
    logic [15:0]                goal;
    logic [15:0]                ramp_cnt;
    logic [95:0]                eval_prev;
    logic                       wr_evt;
    logic                       rd_evt;
    logic [3:0]                 exp_shift;
    logic signed [31:0]         trim_s;
    logic signed [31:0]         max_s;
    logic signed [31:0]         min_s;
    logic signed [31:0]         base_s;
    logic signed [31:0]         sum_s;
    logic signed [31:0]         lim_s;
    logic signed [31:0]         dac_max;
    logic signed [31:0]         wr_units;
    logic                       over;
    logic                       under;
    logic                       eval;
    logic                       warn_evt;
    logic                       trim_ok;
    logic                       margin_ok;
    logic                       invalid_evt;
    logic [15:0]                next_goal;

    function automatic logic signed [31:0] to_units(input logic [15:0] v, input logic sgn, input logic [3:0] sh);
        logic signed [31:0] ext;
        ext = sgn ? {{16{v[15]}}, v} : {16'h0000, v};
        return ext <<< sh;
    endfunction

    // Link domain, clocked by the host's serial clock

    // Reset and read-answer handshake brought across on serial clock edges
    always_ff @(negedge pmb_scl)
    begin
        lrst_s1  <= rst_n;
        lrst_s2  <= lrst_s1;
        rdack_s1 <= rd_ack;
        rdack_s2 <= rdack_s1;
    end

    always_ff @(posedge pmb_scl)
    begin
        sda_pos <= pmb_sda_i;
    end

    // Data only moves while the clock is low, so a fall within one high phase is a start
    assign start_seen = !pmb_sda_i && (sda_pos || lstate == vtlm_pkg::LS_IDLE);
    assign rx_byte    = {rx_shift[6:0], sda_pos};
    assign rd_ready   = (rdack_s2 == rd_tog);
    assign tx_word    = rd_ready ? rd_data : {vtlm_pkg::IDLE_BYTE, vtlm_pkg::IDLE_BYTE};

    always_comb
    begin
        case (lstate)
            vtlm_pkg::LS_ADDR: ack_now = (rx_byte[7:1] == DEV_ADDR);
            vtlm_pkg::LS_CMD:  ack_now = (rx_byte == vtlm_pkg::CMD_TRIM) || (rx_byte == vtlm_pkg::CMD_MAX)
                                      || (rx_byte == vtlm_pkg::CMD_MARGIN_HIGH);
            vtlm_pkg::LS_DLO:  ack_now = 1'b1;
            vtlm_pkg::LS_DHI:  ack_now = 1'b1;
            default:           ack_now = 1'b0;
        endcase
    end

    // Word transfers only: address, command, two data bytes low first
    always_ff @(negedge pmb_scl)
    begin
        if (!lrst_s2)
        begin
            lstate     <= vtlm_pkg::LS_IDLE;
            bit_cnt    <= 4'h0;
            rx_shift   <= 8'h00;
            tx_shift   <= 8'h00;
            tx_hi      <= 8'h00;
            rw_read    <= 1'b0;
            lcmd       <= 8'h00;
            data_lo    <= 8'h00;
            wr_hold    <= '0;
            wr_tog     <= 1'b0;
            rd_tog     <= 1'b0;
            pmb_sda_oe <= 1'b0;
        end
        else if (start_seen)
        begin
            lstate     <= vtlm_pkg::LS_ADDR;
            bit_cnt    <= 4'h0;
            pmb_sda_oe <= 1'b0;
        end
        else
        begin
            bit_cnt <= (bit_cnt == vtlm_pkg::BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
            case (lstate)
                vtlm_pkg::LS_ADDR, vtlm_pkg::LS_CMD, vtlm_pkg::LS_DLO, vtlm_pkg::LS_DHI:
                begin
                    if (bit_cnt != vtlm_pkg::BIT_ACK)
                        rx_shift <= rx_byte;
                    if (bit_cnt == vtlm_pkg::BIT_LAST)
                    begin
                        pmb_sda_oe <= ack_now;
                        if (lstate == vtlm_pkg::LS_ADDR)
                            rw_read <= rx_byte[0];
                        if (lstate == vtlm_pkg::LS_CMD)
                            lcmd <= rx_byte;
                        if (lstate == vtlm_pkg::LS_DLO)
                            data_lo <= rx_byte;
                        if (lstate == vtlm_pkg::LS_DHI)
                            wr_hold <= '{cmd: lcmd, data: {rx_byte, data_lo}};
                    end
                    else if (bit_cnt == vtlm_pkg::BIT_ACK)
                    begin
                        pmb_sda_oe <= 1'b0;
                        if (!pmb_sda_oe)
                            lstate <= vtlm_pkg::LS_SKIP;
                        else if (lstate == vtlm_pkg::LS_ADDR && rw_read)
                        begin
                            pmb_sda_oe <= ~tx_word[7];
                            tx_shift   <= {tx_word[6:0], 1'b0};
                            tx_hi      <= tx_word[15:8];
                            lstate     <= vtlm_pkg::LS_RLO;
                        end
                        else if (lstate == vtlm_pkg::LS_ADDR)
                            lstate <= vtlm_pkg::LS_CMD;
                        else if (lstate == vtlm_pkg::LS_CMD)
                        begin
                            // Ask for read data now; a repeated start leaves ample edges to answer
                            rd_tog <= ~rd_tog;
                            lstate <= vtlm_pkg::LS_DLO;
                        end
                        else if (lstate == vtlm_pkg::LS_DLO)
                            lstate <= vtlm_pkg::LS_DHI;
                        else
                        begin
                            wr_tog <= ~wr_tog;
                            lstate <= vtlm_pkg::LS_SKIP;
                        end
                    end
                end
                vtlm_pkg::LS_RLO, vtlm_pkg::LS_RHI:
                begin
                    if (bit_cnt < vtlm_pkg::BIT_LAST)
                    begin
                        pmb_sda_oe <= ~tx_shift[7];
                        tx_shift   <= {tx_shift[6:0], 1'b0};
                    end
                    else if (bit_cnt == vtlm_pkg::BIT_LAST)
                        pmb_sda_oe <= 1'b0;
                    else if (lstate == vtlm_pkg::LS_RLO && !sda_pos)
                    begin
                        pmb_sda_oe <= ~tx_hi[7];
                        tx_shift   <= {tx_hi[6:0], 1'b0};
                        lstate     <= vtlm_pkg::LS_RHI;
                    end
                    else
                        lstate <= vtlm_pkg::LS_SKIP;
                end
                default:
                    pmb_sda_oe <= 1'b0;
            endcase
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(negedge pmb_scl)
    begin
        pmb_sda_o <= 1'b0;
    end

    // System domain

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            {wr_s1, wr_s2, wr_s3} <= 3'h0;
            {rd_s1, rd_s2, rd_s3} <= 3'h0;
        end
        else
        begin
            {wr_s1, wr_s2, wr_s3} <= {wr_tog, wr_s1, wr_s2};
            {rd_s1, rd_s2, rd_s3} <= {rd_tog, rd_s1, rd_s2};
        end
    end

    assign wr_evt = wr_s2 ^ wr_s3;
    assign rd_evt = rd_s2 ^ rd_s3;

    // Exponent field clipped to the supported span
    always_comb
    begin
        if ($signed(vout_exp) < vtlm_pkg::EXP_MIN)
            exp_shift = 4'h0;
        else if ($signed(vout_exp) > vtlm_pkg::EXP_MAX)
            exp_shift = 4'(vtlm_pkg::EXP_MAX - vtlm_pkg::EXP_MIN);
        else
            exp_shift = 4'($signed(vout_exp) - vtlm_pkg::EXP_MIN);
    end

    always_comb
    begin
        case (loop_scale)
            vtlm_pkg::VTLM_SCALE_1:   dac_max = vtlm_pkg::DAC_MAX_S1;
            vtlm_pkg::VTLM_SCALE_05:  dac_max = vtlm_pkg::DAC_MAX_S05;
            vtlm_pkg::VTLM_SCALE_025: dac_max = vtlm_pkg::DAC_MAX_S025;
            default:                  dac_max = vtlm_pkg::DAC_MAX_S0125;
        endcase
    end

    assign trim_s   = to_units(trim, 1'b1, exp_shift);
    assign max_s    = to_units(vmax, 1'b0, exp_shift);
    assign min_s    = to_units(vout_min, 1'b0, exp_shift);
    assign wr_units = to_units(wr_hold.data, wr_hold.cmd == vtlm_pkg::CMD_TRIM, exp_shift);

    // Margin is unsigned; relative format offsets it from the command
    always_comb
    begin
        if (!margin_high_sel)
            base_s = to_units(vout_command, 1'b0, exp_shift);
        else if (vout_rel)
            base_s = to_units(vout_command, 1'b0, exp_shift) + to_units(margin, 1'b0, exp_shift);
        else
            base_s = to_units(margin, 1'b0, exp_shift);
    end

    // Limits first for the warning, then the DAC ceiling, which never warns
    assign sum_s = base_s + trim_s;
    assign over  = sum_s > max_s;
    assign under = sum_s < min_s;
    assign lim_s = over ? max_s : (under ? min_s : sum_s);

    always_comb
    begin
        if (lim_s < 0)
            next_goal = 16'h0000;
        else if (lim_s > dac_max)
            next_goal = dac_max[15:0];
        else
            next_goal = lim_s[15:0];
    end

    assign eval      = {sum_s, max_s, min_s} != eval_prev;
    assign warn_evt  = eval && (over || under);
    assign trim_ok   = (wr_units <= dac_max) && (wr_units >= -dac_max);
    assign margin_ok = wr_units <= vtlm_pkg::DAC_MAX_S0125;
    assign invalid_evt = wr_evt && (((wr_hold.cmd == vtlm_pkg::CMD_TRIM) && !trim_ok)
                      || ((wr_hold.cmd == vtlm_pkg::CMD_MARGIN_HIGH) && !margin_ok));

    // Register file; rejected words leave the old value in place
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            trim   <= vtlm_pkg::TRIM_RST;
            vmax   <= vtlm_pkg::MAX_RST;
            margin <= vtlm_pkg::MARGIN_HIGH_RST;
        end
        else if (wr_evt)
        begin
            if (wr_hold.cmd == vtlm_pkg::CMD_TRIM && trim_ok)
                trim <= wr_hold.data;
            if (wr_hold.cmd == vtlm_pkg::CMD_MAX)
                vmax <= wr_hold.data;
            if (wr_hold.cmd == vtlm_pkg::CMD_MARGIN_HIGH && margin_ok)
                margin <= wr_hold.data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rd_data <= 16'h0000;
            rd_ack  <= 1'b0;
        end
        else if (rd_evt)
        begin
            case (lcmd)
                vtlm_pkg::CMD_TRIM: rd_data <= trim;
                vtlm_pkg::CMD_MAX:  rd_data <= vmax;
                default:            rd_data <= margin;
            endcase
            rd_ack <= ~rd_ack;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            goal      <= 16'h0000;
            eval_prev <= '0;
        end
        else
        begin
            goal      <= next_goal;
            eval_prev <= {sum_s, max_s, min_s};
        end
    end

    // One LSB per interval; stepping is skipped while conversion is off
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dac_ref  <= 16'h0000;
            ramp_cnt <= 16'h0000;
        end
        else if (!conv_en)
        begin
            dac_ref  <= goal;
            ramp_cnt <= 16'h0000;
        end
        else if (dac_ref == goal)
            ramp_cnt <= 16'h0000;
        else if (ramp_cnt >= ramp_interval)
        begin
            ramp_cnt <= 16'h0000;
            dac_ref  <= (dac_ref < goal) ? dac_ref + 16'h0001 : dac_ref - 16'h0001;
        end
        else
            ramp_cnt <= ramp_cnt + 16'h0001;
    end

    // Setting wins over a clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            status <= '0;
        else
        begin
            status.none_above  <= warn_evt || (status.none_above && !status_clear);
            status.word_vout   <= warn_evt || (status.word_vout && !status_clear);
            status.vout_maxmin <= warn_evt || (status.vout_maxmin && !status_clear);
            status.cml_invalid <= invalid_evt || (status.cml_invalid && !status_clear);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pmb_alert_o  <= 1'b0;
            pmb_alert_oe <= 1'b0;
        end
        else
        begin
            pmb_alert_o  <= 1'b0;
            pmb_alert_oe <= |status;
        end
    end

    // Backup byte is already in 2^-12 units, so only saturation remains
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            nvm_trim_byte <= 8'h00;
        else if (trim_s > vtlm_pkg::NVM_BYTE_MAX)
            nvm_trim_byte <= 8'h7f;
        else if (trim_s < vtlm_pkg::NVM_BYTE_MIN)
            nvm_trim_byte <= 8'h80;
        else
            nvm_trim_byte <= trim_s[7:0];
    end

    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ref_step_one: assert property (conv_en && $past(conv_en) && $past(rst_n) |->
        (dac_ref == $past(dac_ref)) || (dac_ref == $past(dac_ref) + 16'h0001) || (dac_ref == $past(dac_ref) - 16'h0001))
        else $error("reference moved more than one step");
    a_goal_dac_ceiling: assert property (##1 (goal <= $past(dac_max)))
        else $error("target above DAC ceiling");
    a_goal_upper_bound: assert property (##1 ($signed({16'h0000, goal}) <= $past(max_s)))
        else $error("target above upper bound");
    a_warn_status_bits: assert property (warn_evt |=> status.none_above && status.word_vout ##1 pmb_alert_oe)
        else $error("warning did not set status and alert");
    a_dac_silent_clamp: assert property (eval && !over && !under && sum_s > dac_max && !status.vout_maxmin
        |=> goal == $past(dac_max[15:0]) && !status.vout_maxmin)
        else $error("DAC clamp wrong or warned");
    a_trim_bad_kept: assert property (wr_evt && wr_hold.cmd == vtlm_pkg::CMD_TRIM && !trim_ok
        |=> $stable(trim) && status.cml_invalid)
        else $error("invalid trim accepted");
    a_trim_good_stored: assert property (wr_evt && wr_hold.cmd == vtlm_pkg::CMD_TRIM && trim_ok
        |=> trim == $past(wr_hold.data))
        else $error("valid trim not stored");
    a_nvm_byte_sat: assert property (trim_s > vtlm_pkg::NVM_BYTE_MAX |=> nvm_trim_byte == 8'h7f)
        else $error("backup byte not saturated");
    a_over_to_bound: assert property (over && max_s <= dac_max |=> goal == $past(max_s[15:0]))
        else $error("over-limit target not set to bound");

endmodule
`default_nettype wire

// *** tb/output_offset_adjust_limit_margin_regs_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module output_offset_adjust_limit_margin_regs_test;
    logic                  sys_clk = 1'b0;
    logic                  rst_n = 1'b0;
    wire logic             scl;
    wire logic             host_oe;
    logic                  sda_oe;
    logic                  alert_oe;
    logic                  alert_o;
    logic                  sda_o;
    wire logic             sda = ~(host_oe | sda_oe);
    logic [15:0]           cmd_v = 16'h03e8;
    logic [15:0]           min_v = 16'h0000;
    logic [4:0]            expo = 5'h14;
    logic                  rel = 1'b0;
    logic                  mh_sel = 1'b0;
    logic                  conv = 1'b0;
    vtlm_pkg::vtlm_scale_t scale = vtlm_pkg::VTLM_SCALE_0125;
    logic [15:0]           ramp = 16'h0003;
    logic                  clr = 1'b0;
    logic [15:0]           dac;
    logic [7:0]            nvm;
    vtlm_pkg::vtlm_status_t st;
    int                    err_count = 0;
    int                    cmp_count = 0;
    always #20 sys_clk = ~sys_clk;
    vtlm_host_model host (.scl(scl), .sda_oe(host_oe), .sda(sda));
    vtlm_core dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .pmb_scl(scl), .pmb_sda_i(sda), .pmb_sda_o(sda_o), .pmb_sda_oe(sda_oe),
        .pmb_alert_o(alert_o), .pmb_alert_oe(alert_oe), .vout_command(cmd_v), .vout_min(min_v), .vout_exp(expo),
        .vout_rel(rel), .margin_high_sel(mh_sel), .conv_en(conv), .loop_scale(scale), .ramp_interval(ramp),
        .status_clear(clr), .dac_ref(dac), .nvm_trim_byte(nvm), .status(st)
    );
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic exp_nak = 1'b0);
        logic n;
        host.write_word(c, d, n);
        chk("nak", {15'h0, n}, {15'h0, exp_nak});
        repeat (10) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] d;
        logic        n;
        host.read_word(c, d, n);
        chk("read nak", {15'h0, n}, 16'h0000);
        chk("read", d, exp);
    endtask
    task automatic clear_status;
        @(posedge sys_clk) #1 clr = 1'b1;
        @(posedge sys_clk) #1 clr = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("cleared", {12'h0, st}, 16'h0000);
    endtask
    task automatic t_reset;
        rd(8'h22, 16'h0000);
        rd(8'h24, 16'hffff);
        rd(8'h25, 16'h0000);
        wr(8'h23, 16'h1234, 1'b1);
        chk("dac", dac, 16'h03e8);
    endtask
    task automatic t_trim;
        wr(8'h22, 16'h0032);
        chk("dac", dac, 16'h03e8 + 16'h0032);
        chk("nvm", {8'h0, nvm}, 16'h0032);
        rd(8'h22, 16'h0032);
        wr(8'h22, 16'hfed4);
        chk("dac", dac, 16'h03e8 - 16'h012c);
        chk("nvm", {8'h0, nvm}, 16'h0080);
        wr(8'h22, 16'h012c);
        chk("nvm", {8'h0, nvm}, 16'h007f);
    endtask
    task automatic t_limit;
        wr(8'h24, 16'h044c);
        chk("dac", dac, 16'h044c);
        chk("status", {12'h0, st}, 16'h000e);
        chk("alert", {15'h0, alert_oe}, 16'h0001);
        chk("pin level", {14'h0, alert_o, sda_o}, 16'h0000);
        min_v = 16'h0384;
        clear_status();
        wr(8'h22, 16'hfed4);
        chk("dac", dac, 16'h0384);
        chk("status", {12'h0, st}, 16'h000e);
        clear_status();
        min_v = 16'h0000;
        wr(8'h24, 16'hffff);
        chk("dac", dac, 16'h02bc);
    endtask
    task automatic t_dac;
        scale = vtlm_pkg::VTLM_SCALE_1;
        cmd_v = 16'h0af0;
        wr(8'h22, 16'h0064);
        chk("dac", dac, 16'(vtlm_pkg::DAC_MAX_S1));
        chk("status", {12'h0, st}, 16'h0000);
        wr(8'h22, 16'h0bb8);
        chk("status", {12'h0, st}, 16'h0001);
        rd(8'h22, 16'h0064);
        clear_status();
        scale = vtlm_pkg::VTLM_SCALE_0125;
    endtask
    task automatic t_margin;
        mh_sel = 1'b1;
        wr(8'h25, 16'h07d0);
        chk("dac", dac, 16'h07d0 + 16'h0064);
        rel = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        chk("dac", dac, 16'h0af0 + 16'h07d0 + 16'h0064);
        wr(8'h24, 16'h0800);
        chk("dac", dac, 16'h0800);
        clear_status();
        wr(8'h24, 16'hffff);
        rel = 1'b0;
        mh_sel = 1'b0;
        cmd_v = 16'h07d0;
    endtask
    task automatic t_ramp;
        int n;
        wr(8'h22, 16'h0064);
        conv = 1'b1;
        wr(8'h22, 16'h006c);
        chk("mid", {15'h0, dac > 16'h0834 && dac < 16'h083c}, 16'h0001);
        for (n = 0; n < 100 && dac !== 16'h083c; n++)
            @(posedge sys_clk) #1;
        chk("ramped", dac, 16'h083c);
    endtask
    task automatic t_exp;
        conv = 1'b0;
        cmd_v = 16'h0100;
        expo = 5'h18;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("exp", dac, 16'h16c0);
        expo = 5'h13;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("exp clip", dac, 16'h016c);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        host.pulses(4);
        @(posedge sys_clk) #1 rst_n = 1'b1;
        host.pulses(4);
        t_reset();
        t_trim();
        t_limit();
        t_dac();
        t_margin();
        t_ramp();
        t_exp();
        results();
    end
endmodule
`default_nettype wire

// *** tb/vtlm_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module vtlm_host_model #(
    parameter logic [6:0] ADDR = 7'h40
) (
    // Link wires
    output var logic scl,
    output var logic sda_oe,
    input  wire logic sda
);
    localparam realtime Q = 31.25;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // One link clock; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic seen);
        scl = 1'b0;
        #Q sda_oe = ~b;
        #Q scl = 1'b1;
        #Q seen = sda;
        #Q scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ack, nak);
    endtask
    // A released data line is sampled high first so the device can resync
    task automatic start;
        scl = 1'b0;
        #Q sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
    endtask
    task automatic stop;
        scl = 1'b0;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #400;
    endtask
    task automatic pulses(input int n);
        logic s;
        repeat (n) bit_io(1'b1, s);
        scl = 1'b1;
    endtask
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic nak);
        logic [7:0] r;
        logic [3:0] n;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, r, n[0]);
        byte_io(cmd, 1'b1, r, n[1]);
        byte_io(d[7:0], 1'b1, r, n[2]);
        byte_io(d[15:8], 1'b1, r, n[3]);
        stop();
        nak = |n;
    endtask
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic nak);
        logic [7:0] r;
        logic [3:0] n;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, r, n[0]);
        byte_io(cmd, 1'b1, r, n[1]);
        start();
        byte_io({ADDR, 1'b1}, 1'b1, r, n[2]);
        byte_io(8'hff, 1'b0, d[7:0], n[3]);
        byte_io(8'hff, 1'b1, d[15:8], nak);
        stop();
        nak = |n;
    endtask
endmodule
`default_nettype wire
